/* File: hw/mrt_regs.sv */
// Purpose: Rate, ideality trim and converter result registers of the monitor device
// Assumes: Host port decoder delivers one-cycle read/write strobes on core_clk
// Notes:   Port style strap is caught after reset release and fixes field layout
`timescale 1ns/1ps
`default_nettype none
module mrt_regs
   import mrt_pkg::*;
#(
   parameter int CYCLE_PER_MS = CYC_PER_MS
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        port_is_iic,
   input  wire mrt_req_s    host_req,
   input  wire mrt_conv_s   conv_in,
   input  wire logic [11:0] remote_raw,
   output logic [15:0]      host_rdata,
   output logic             host_rvalid,
   output logic [2:0]       rate_code,
   output logic signed [7:0] remote_one_trim,
   output logic signed [7:0] remote_two_trim,
   output logic [12:0]      remote_one_corr,
   output logic             cycle_done
);
   typedef struct packed {
      logic [1:0]       strap_sync;
      logic             strap_seen;
      logic [1:0]       strap_age;
      logic             iic;
      logic [2:0]       rate;
      logic [7:0]       trim1;
      logic [7:0]       trim2;
      logic             local_sensor_enable;
      logic             remote_one_enable;
      logic             remote_two_enable;
      logic             series_resistance_correction;
      logic [15:0][11:0] res;
      logic [CNT_W-1:0] cnt;
      logic             done;
      logic [15:0]      rdata;
      logic             rvalid;
      logic [12:0]      corr1;
   } st_s;

   st_s st_r;
   st_s st_nxt;
   logic [CNT_W-1:0] cyc_len;
   logic [15:0]      sens_rd;
   logic             any_en;
   logic [1:0]       n_remote;

   // Cycle length from active sensors and correction
   always_comb begin
      n_remote = {1'b0, st_r.remote_one_enable} + {1'b0, st_r.remote_two_enable};
      any_en   = st_r.local_sensor_enable | (n_remote != 2'd0);
      case ({st_r.local_sensor_enable, n_remote})
         3'b100:  cyc_len = CNT_W'(T_LOCAL_MS * CYCLE_PER_MS);
         3'b001:  cyc_len = st_r.series_resistance_correction ?
                            CNT_W'(T_ONE_RC_MS * CYCLE_PER_MS) :
                            CNT_W'(T_ONE_MS * CYCLE_PER_MS);
         3'b101:  cyc_len = st_r.series_resistance_correction ?
                            CNT_W'(T_LOC_ONE_RC_MS * CYCLE_PER_MS) :
                            CNT_W'(T_LOC_ONE_MS * CYCLE_PER_MS);
         3'b010:  cyc_len = st_r.series_resistance_correction ?
                            CNT_W'(T_TWO_RC_MS * CYCLE_PER_MS) :
                            CNT_W'(T_TWO_MS * CYCLE_PER_MS);
         3'b110:  cyc_len = st_r.series_resistance_correction ?
                            CNT_W'(T_ALL_RC_MS * CYCLE_PER_MS) :
                            CNT_W'(T_ALL_MS * CYCLE_PER_MS);
         default: cyc_len = CNT_W'(T_LOCAL_MS * CYCLE_PER_MS);
      endcase
   end

   // Sensor configuration readback in the active layout
   always_comb begin
      sens_rd = 16'h0000;
      if (st_r.iic) begin
         sens_rd[7:0]        = IIC_LOW_RSVD;
         sens_rd[IIC_RC_BIT] = st_r.series_resistance_correction;
         sens_rd[IIC_LT_BIT] = st_r.local_sensor_enable;
         sens_rd[IIC_D1_BIT] = st_r.remote_one_enable;
         sens_rd[IIC_D2_BIT] = st_r.remote_two_enable;
      end else begin
         sens_rd[SPI_RC_BIT] = st_r.series_resistance_correction;
         sens_rd[SPI_LT_BIT] = st_r.local_sensor_enable;
         sens_rd[SPI_D1_BIT] = st_r.remote_one_enable;
         sens_rd[SPI_D2_BIT] = st_r.remote_two_enable;
      end
   end

   // Next-state logic
   always_comb begin
      st_nxt            = st_r;
      st_nxt.rvalid     = 1'b0;
      st_nxt.done       = 1'b0;
      // Strap synchroniser, layout latched once after release
      st_nxt.strap_sync = {st_r.strap_sync[0], port_is_iic};
      // Wait until the second flop holds the pin level, then latch it
      if (!st_r.strap_seen) begin
         if (st_r.strap_age == 2'h2) begin
            st_nxt.strap_seen = 1'b1;
            st_nxt.iic        = st_r.strap_sync[1];
         end else begin
            st_nxt.strap_age  = st_r.strap_age + 2'h1;
         end
      end
      // Host writes
      if (host_req.wr) begin
         case (host_req.addr)
            ADDR_PACE: st_nxt.rate = st_r.iic ?
                          host_req.wdata[IIC_RATE_LSB +: 3] :
                          host_req.wdata[SPI_RATE_LSB +: 3];
            ADDR_TRIM_ONE: st_nxt.trim1 = st_r.iic ?
                          host_req.wdata[IIC_TRIM_LSB +: 8] :
                          host_req.wdata[SPI_TRIM_LSB +: 8];
            ADDR_TRIM_TWO: st_nxt.trim2 = st_r.iic ?
                          host_req.wdata[IIC_TRIM_LSB +: 8] :
                          host_req.wdata[SPI_TRIM_LSB +: 8];
            ADDR_SENS_CFG: begin
               st_nxt.series_resistance_correction =
                  host_req.wdata[st_r.iic ? IIC_RC_BIT : SPI_RC_BIT];
               st_nxt.local_sensor_enable =
                  host_req.wdata[st_r.iic ? IIC_LT_BIT : SPI_LT_BIT];
               st_nxt.remote_one_enable =
                  host_req.wdata[st_r.iic ? IIC_D1_BIT : SPI_D1_BIT];
               st_nxt.remote_two_enable =
                  host_req.wdata[st_r.iic ? IIC_D2_BIT : SPI_D2_BIT];
            end
            default: ;
         endcase
      end
      // Host reads, answered one cycle later
      if (host_req.rd) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = 16'h0000;
         if (host_req.addr == ADDR_PACE)
            st_nxt.rdata = st_r.iic ? {5'h00, st_r.rate, IIC_LOW_RSVD} :
                                      {13'h0000, st_r.rate};
         else if (host_req.addr == ADDR_TRIM_ONE)
            st_nxt.rdata = st_r.iic ? {st_r.trim1, IIC_LOW_RSVD} : {8'h00, st_r.trim1};
         else if (host_req.addr == ADDR_TRIM_TWO)
            st_nxt.rdata = st_r.iic ? {st_r.trim2, IIC_LOW_RSVD} : {8'h00, st_r.trim2};
         else if (host_req.addr == ADDR_SENS_CFG)
            st_nxt.rdata = sens_rd;
         else if (host_req.addr >= ADDR_RES_FIRST && host_req.addr <= ADDR_RES_LAST)
            st_nxt.rdata = {4'h0,
               st_r.res[4'(host_req.addr - ADDR_RES_FIRST)]};
      end
      // Converter results; differential code is already two's complement
      if (conv_in.valid) begin
         if (conv_in.diff)
            st_nxt.res[{conv_in.chan[3:2], 2'b00} | {2'b00, conv_in.chan[1], 1'b0}] =
               conv_in.code;
         else
            st_nxt.res[conv_in.chan] = conv_in.code;
      end
      // Monitoring cycle timer, paced by the enabled sensor set
      if (!any_en) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt >= cyc_len - CNT_W'(1)) begin
         st_nxt.cnt  = '0;
         st_nxt.done = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
      // Signed trim correction on remote one result
      st_nxt.corr1 = 13'({1'b0, remote_raw}) +
                     13'(signed'({{5{st_r.trim1[7]}}, st_r.trim1}));
   end

   // State register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r                              <= '0;
         st_r.rate                         <= RATE_RST;
         st_r.trim1                        <= TRIM_RST;
         st_r.trim2                        <= TRIM_RST;
         st_r.local_sensor_enable          <= 1'b1;
         st_r.remote_one_enable            <= 1'b1;
         st_r.remote_two_enable            <= 1'b1;
         st_r.series_resistance_correction <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state flops
   assign host_rdata      = st_r.rdata;
   assign host_rvalid     = st_r.rvalid;
   assign rate_code       = st_r.rate;
   assign remote_one_trim = st_r.trim1;
   assign remote_two_trim = st_r.trim2;
   assign remote_one_corr = st_r.corr1;
   assign cycle_done      = st_r.done;
endmodule
`default_nettype wire

/* File: hw/mrt_pkg.sv */
// Purpose: Constants and carriers for the monitor rate, trim and result register bank
// Assumes: 16-bit registers, 7-bit register addresses, one 20 MHz core clock
// Notes:   Field positions and reset values differ between the two host port styles
package mrt_pkg;
   // Register addresses
   localparam logic [6:0]  ADDR_PACE       = 7'h0B;
   localparam logic [6:0]  ADDR_TRIM_ONE   = 7'h21;
   localparam logic [6:0]  ADDR_TRIM_TWO   = 7'h22;
   localparam logic [6:0]  ADDR_RES_FIRST  = 7'h23;
   localparam logic [6:0]  ADDR_RES_LAST   = 7'h32;
   localparam logic [6:0]  ADDR_SENS_CFG   = 7'h0A;
   // Field positions, serial-peripheral style port
   localparam int          SPI_RATE_LSB    = 0;
   localparam int          SPI_TRIM_LSB    = 0;
   localparam int          SPI_RC_BIT      = 2;
   localparam int          SPI_LT_BIT      = 3;
   localparam int          SPI_D1_BIT      = 4;
   localparam int          SPI_D2_BIT      = 5;
   // Field positions, two-wire style port
   localparam int          IIC_RATE_LSB    = 8;
   localparam int          IIC_TRIM_LSB    = 8;
   localparam int          IIC_RC_BIT      = 10;
   localparam int          IIC_LT_BIT      = 11;
   localparam int          IIC_D1_BIT      = 12;
   localparam int          IIC_D2_BIT      = 13;
   // Reset values
   localparam logic [2:0]  RATE_RST        = 3'h7;
   localparam logic [7:0]  TRIM_RST        = 8'h00;
   localparam logic [7:0]  IIC_LOW_RSVD    = 8'hFF;
   localparam logic [15:0] SPI_PACE_RST    = 16'h0007;
   localparam logic [15:0] IIC_PACE_RST    = 16'h07FF;
   localparam logic [15:0] SPI_TRIM_RSTV   = 16'h0000;
   localparam logic [15:0] IIC_TRIM_RSTV   = 16'h00FF;
   localparam logic [15:0] RES_RST         = 16'h0000;
   // Monitoring cycle times in ms
   localparam int          T_LOCAL_MS      = 15;
   localparam int          T_ONE_MS        = 44;
   localparam int          T_ONE_RC_MS     = 93;
   localparam int          T_LOC_ONE_MS    = 59;
   localparam int          T_LOC_ONE_RC_MS = 108;
   localparam int          T_TWO_MS        = 88;
   localparam int          T_TWO_RC_MS     = 186;
   localparam int          T_ALL_MS        = 103;
   localparam int          T_ALL_RC_MS     = 201;
   localparam int          CLK_KHZ         = 20000;
   localparam int          CYC_PER_MS      = CLK_KHZ;
   localparam int          CNT_W           = 24;
   // Host register access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } mrt_req_s;
   // Converter result delivery
   typedef struct packed {
      logic        valid;
      logic [3:0]  chan;
      logic        diff;
      logic [11:0] code;
   } mrt_conv_s;
endpackage

/* File: verif/mrt_regs_properties.sv */
// Purpose: Port relations of the rate, trim and result register bank
// Assumes: Strap moves only while reset is high
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module mrt_regs_properties
   import mrt_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              port_is_iic,
   input wire mrt_req_s          host_req,
   input wire mrt_conv_s         conv_in,
   input wire logic [11:0]       remote_raw,
   input wire logic [15:0]       host_rdata,
   input wire logic              host_rvalid,
   input wire logic [2:0]        rate_code,
   input wire logic signed [7:0] remote_one_trim,
   input wire logic signed [7:0] remote_two_trim,
   input wire logic [12:0]       remote_one_corr,
   input wire logic              cycle_done
);
   // One clock, one reset for every check
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_read_answer: assert property (host_req.rd |=> host_rvalid)
      else $error("read not answered");
   a_answer_cause: assert property (host_rvalid |-> $past(host_req.rd))
      else $error("answer without read");
   a_rate_write: assert property (host_req.wr && host_req.addr == ADDR_PACE |=>
      rate_code == (port_is_iic ? $past(host_req.wdata[10:8]) : $past(host_req.wdata[2:0])))
      else $error("rate field misplaced");
   a_rate_hold: assert property (!(host_req.wr && host_req.addr == ADDR_PACE) |=>
      $stable(rate_code))
      else $error("rate changed without write");
   a_trim_one: assert property (host_req.wr && host_req.addr == ADDR_TRIM_ONE |=>
      remote_one_trim == $past(port_is_iic ? host_req.wdata[15:8] : host_req.wdata[7:0]))
      else $error("first trim misplaced");
   a_trim_two: assert property (host_req.wr && host_req.addr == ADDR_TRIM_TWO |=>
      remote_two_trim == $past(port_is_iic ? host_req.wdata[15:8] : host_req.wdata[7:0]))
      else $error("second trim misplaced");
   a_corr_sum: assert property (!$past(rst) |-> remote_one_corr ==
      13'({1'b0, $past(remote_raw)} + {{5{$past(remote_one_trim[7])}}, $past(remote_one_trim)}))
      else $error("trim correction wrong");
   a_done_single: assert property (cycle_done |=> !cycle_done [*8])
      else $error("cycle pulse too long");
endmodule
`default_nettype wire

/* File: verif/mrt_host.sv */
// Purpose: Host processor model issuing register reads and writes
// Assumes: Answer comes one cycle after the read edge
// Notes:   A missing answer yields unknown data so compares fail
`timescale 1ns/1ps
`default_nettype none
module mrt_host
   import mrt_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic [15:0] host_rdata,
   input  wire logic        host_rvalid,
   output var mrt_req_s     host_req
);
   // Idle request lines
   initial host_req = '0;
   // One-cycle request, data taken after the answering edge
   task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      @(posedge core_clk);
      host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      host_req <= '0;
      #1 q = host_rvalid ? host_rdata : 16'hXXXX;
   endtask
endmodule
`default_nettype wire

/* File: verif/monitor_rate_trim_result_regs_bench.sv */
// Purpose: Self-checking bench of the rate, trim and result register bank
// Assumes: Timer shortened to two cycles per millisecond
// Notes:   Runs every test once per host port layout
`timescale 1ns/1ps
`default_nettype none
module monitor_rate_trim_result_regs_bench
   import mrt_pkg::*;
;
   logic              core_clk = 1'b0;
   logic              rst = 1'b1;
   logic              port_is_iic = 1'b0;
   mrt_conv_s         conv_in = '0;
   logic [11:0]       remote_raw = 12'h000;
   mrt_req_s          host_req;
   logic [15:0]       host_rdata, lo, d, q;
   logic              host_rvalid, cycle_done;
   logic [2:0]        rate_code;
   logic signed [7:0] remote_one_trim, remote_two_trim;
   logic [12:0]       remote_one_corr;
   logic [7:0]        t;
   int                n_errors = 0, checked = 0, sh, n, res_m[16];
   // Clock
   initial forever #25 core_clk = ~core_clk;
   mrt_regs #(.CYCLE_PER_MS(2)) uut (.core_clk(core_clk), .rst(rst),
      .port_is_iic(port_is_iic), .host_req(host_req), .conv_in(conv_in),
      .remote_raw(remote_raw), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .rate_code(rate_code), .remote_one_trim(remote_one_trim),
      .remote_two_trim(remote_two_trim), .remote_one_corr(remote_one_corr),
      .cycle_done(cycle_done));
   mrt_host host (.core_clk(core_clk), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .host_req(host_req));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
      host.acc(1'b0, a, 16'h0000, q);
      chk(q, e);
   endtask
   // Converter delivery, fresh remote reading alongside
   task automatic conv(input int ch, input logic df, input logic [11:0] c);
      @(posedge core_clk);
      conv_in <= '{1'b1, 4'(ch), df, c};
      remote_raw <= 12'($urandom);
      @(posedge core_clk);
      conv_in <= '0;
   endtask
   // Cycles up to the next monitoring pulse
   task automatic gap(output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (cycle_done !== 1'b1 && n < 1000);
   endtask
   // Cycle time in ms; bit0 local, bit1 first remote, bit2 second remote
   function automatic int ms(int e, int rc);
      case (e)
         1: return 15;
         2, 4: return rc ? 93 : 44;
         3, 5: return rc ? 108 : 59;
         6: return rc ? 186 : 88;
         default: return rc ? 201 : 103;
      endcase
   endfunction
   // Watchdog
   initial begin
      #(60000 * 50);
      n_errors++;
      results();
   end
   initial begin
      void'($urandom(19917));
      for (int iic = 0; iic < 2; iic++) begin
         rst <= 1'b1;
         port_is_iic <= iic[0];
         repeat (5) @(posedge core_clk);
         rst <= 1'b0;
         repeat (4) @(posedge core_clk);
         sh = iic * 8;
         lo = iic ? 16'h00FF : 16'h0000;
         rdchk(ADDR_PACE, (16'h0007 << sh) | lo);
         rdchk(ADDR_TRIM_ONE, lo);
         rdchk(ADDR_TRIM_TWO, lo);
         rdchk(7'h7F, 16'h0000);
         rdchk(ADDR_SENS_CFG, iic ? 16'h3CFF : 16'h003C);
         for (int i = 0; i < 16; i++) rdchk(ADDR_RES_FIRST + 7'(i), 16'h0000);
         for (int r = 0; r < 8; r++) begin
            host.acc(1'b1, ADDR_PACE, 16'(r) << sh, q);
            chk({13'h0000, rate_code}, 16'(r));
            rdchk(ADDR_PACE, (16'(r) << sh) | lo);
         end
         for (int k = 0; k < 4; k++) begin
            t = (k == 3) ? 8'($urandom) : 8'h7F + 8'(k);
            d = 16'($urandom);
            d[sh +: 8] = t;
            host.acc(1'b1, ADDR_TRIM_ONE, d, q);
            host.acc(1'b1, ADDR_TRIM_TWO, d, q);
            rdchk(ADDR_TRIM_ONE, (16'(t) << sh) | lo);
            rdchk(ADDR_TRIM_TWO, (16'(t) << sh) | lo);
            chk({8'h00, remote_one_trim}, 16'(t));
            chk({8'h00, remote_two_trim}, 16'(t));
            conv(0, 1'b0, 12'h000);
            #1 chk(16'(remote_one_corr), 16'(13'({1'b0, remote_raw} + {{5{t[7]}}, t})));
         end
         for (int i = 0; i < 16; i++) begin
            res_m[i] = $urandom_range(4095);
            conv(i, 1'b0, 12'(res_m[i]));
            host.acc(1'b1, ADDR_RES_FIRST + 7'(i), 16'($urandom), q);
         end
         for (int i = 0; i < 16; i++) rdchk(ADDR_RES_FIRST + 7'(i), 16'(res_m[i]));
         for (int i = 1; i < 4; i += 2) begin
            res_m[i & 2] = (i == 1) ? 32'h800 : $urandom_range(4095);
            conv(i, 1'b1, 12'(res_m[i & 2]));
            rdchk(ADDR_RES_FIRST + 7'(i & 2), 16'(res_m[i & 2]));
         end
         for (int e = 1; e < 8; e++)
            for (int rc = 0; rc < 2; rc++) begin
               host.acc(1'b1, ADDR_SENS_CFG, 16'((e * 2 + rc) << (iic ? 10 : 2)), q);
               rdchk(ADDR_SENS_CFG, 16'((e * 2 + rc) << (iic ? 10 : 2)) | lo);
               gap(n);
               gap(n);
               chk(16'(n), 16'(2 * ms(e, rc)));
            end
      end
      results();
   end
endmodule
bind mrt_regs mrt_regs_properties u_props (.core_clk(core_clk), .rst(rst),
   .port_is_iic(port_is_iic), .host_req(host_req), .conv_in(conv_in),
   .remote_raw(remote_raw), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
   .rate_code(rate_code), .remote_one_trim(remote_one_trim),
   .remote_two_trim(remote_two_trim), .remote_one_corr(remote_one_corr),
   .cycle_done(cycle_done));
`default_nettype wire
